// *** hw/phy_cfg_regs.sv ***
// phy_cfg_regs: transceiver configuration register bank behind a
// classic Wishbone slave, driving self-test, clock delay, receiver tuning,
// clock-out select and serial interface width.
// assumes: one clock, synchronous active-low reset, delay straps are
// static pins held steady across reset release.
//
// Summary of operation
// R1: packet length register sets generated packet bytes
// R2: lead-in of 13 nibbles 0x5, then 0xd5
// R3: 8-bit gap field idles between packets, 0x7d
// R4: each gap unit adds four bytes
// R5: reserved bits ignore writes, read zero
// R6: tx delay code from straps, software writable
// R7: rx delay code from straps, software writable
// R8: select bit routes test clock to clock-out
// R9: bit 14 picks six-wire or four-wire mode
// R10: writable sixteen-bit receiver equalizer word
// R11: writable sixteen-bit receiver low-pass word
// R12: writable sixteen-bit equalizer enable word
// R13: whole-word access, effective after bus completion
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps

module phy_cfg_regs (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// wishbone classic slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [phy_cfg_pkg::WB_AW-1:0] wb_adr_in,
	input wire logic [phy_cfg_pkg::WB_SW-1:0] wb_sel_in,
	input wire logic [phy_cfg_pkg::WB_DW-1:0] wb_dat_in,
	output logic [phy_cfg_pkg::WB_DW-1:0] wb_dat_out,
	output logic wb_ack_out,
	// delay straps, sampled at reset
	input wire logic [3:0] tx_delay_strap_in,
	input wire logic [3:0] rx_delay_strap_in,
	// clock-out path
	input wire logic transmit_test_clock_in,
	input wire logic normal_clock_in,
	output logic clock_out_out,
	// configuration toward the analog and interface logic
	output logic [3:0] tx_clock_delay_code_out,
	output logic [3:0] rx_clock_delay_code_out,
	output logic [phy_cfg_pkg::REG_W-1:0] receiver_equalizer_word_out,
	output logic [phy_cfg_pkg::REG_W-1:0] receiver_lowpass_word_out,
	output logic [phy_cfg_pkg::REG_W-1:0] receiver_equalizer_enable_word_out,
	output logic clock_output_select_out,
	output logic six_wire_mode_out,
	output logic serial_clock_enable_out,
	// self-test stream
	output logic [3:0] selftest_nibble_out,
	output logic selftest_valid_out,
	output logic selftest_packet_done_out
);
	import phy_cfg_pkg::*;

	// ----------------------------------------------------------------
	// strap synchronisers
	// ----------------------------------------------------------------
	// straps are pins: two flops before the reset capture reads them.
	// no reset here so the value is already settled when reset releases.
	logic [7:0] strap_s1_r;
	logic [7:0] strap_s2_r;

	always_ff @(posedge core_clk_in) begin
		strap_s1_r <= {tx_delay_strap_in, rx_delay_strap_in};
		strap_s2_r <= strap_s1_r;
	end

	// ----------------------------------------------------------------
	// wishbone front end
	// ----------------------------------------------------------------
	logic [IDX_W-1:0] idx;
	logic req;
	logic wr_commit;
	logic full_word;
	logic ack_r, ack_nxt;
	logic [WB_DW-1:0] rdat_r, rdat_nxt;
	logic [REG_W-1:0] wdat;

	assign idx = wb_adr_in[WB_AW-1:2];
	assign req = wb_cyc_in && wb_stb_in;
	assign wdat = wb_dat_in[REG_W-1:0];
	// partial-lane writes are dropped so a register never holds half a word
	assign full_word = (wb_sel_in[1:0] == 2'b11); // see R13
	// writes land on the edge where the master samples ack high
	assign wr_commit = req && wb_we_in && ack_r && full_word; // see R13

	// ----------------------------------------------------------------
	// configuration storage
	// ----------------------------------------------------------------
	logic [REG_W-1:0] pkt_len_r, pkt_len_nxt;
	logic [GAP_MSB:0] gap_len_r, gap_len_nxt;
	logic [3:0] tx_dly_r, tx_dly_nxt;
	logic [3:0] rx_dly_r, rx_dly_nxt;
	logic [REG_W-1:0] rx_eq_r, rx_eq_nxt;
	logic [REG_W-1:0] rx_lpf_r, rx_lpf_nxt;
	logic [REG_W-1:0] rx_eq_en_r, rx_eq_en_nxt;
	logic clk_sel_r, clk_sel_nxt;
	logic six_wire_r, six_wire_nxt;
	logic st_run_r, st_run_nxt;
	logic [ST_CNT_MSB:0] st_pkts_r, st_pkts_nxt;

	logic gen_busy;
	logic gen_done;

	// register write decode; unmapped indices fall through untouched
	always_comb begin
		pkt_len_nxt = pkt_len_r;
		gap_len_nxt = gap_len_r;
		tx_dly_nxt = tx_dly_r;
		rx_dly_nxt = rx_dly_r;
		rx_eq_nxt = rx_eq_r;
		rx_lpf_nxt = rx_lpf_r;
		rx_eq_en_nxt = rx_eq_en_r;
		clk_sel_nxt = clk_sel_r;
		six_wire_nxt = six_wire_r;
		st_run_nxt = st_run_r;
		st_pkts_nxt = st_pkts_r;
		// packet counter wraps; a write to the status index clears it
		if (gen_done) begin
			st_pkts_nxt = st_pkts_r + 1'b1;
		end
		if (wr_commit) begin
			case (idx)
				IDX_PKT_LEN: pkt_len_nxt = wdat; // see R1
				IDX_GAP_LEN: gap_len_nxt = wdat[GAP_MSB:0]; // see R3
				IDX_CLK_DLY: begin
					// only the two nibbles are stored, bits above are dropped
					tx_dly_nxt = wdat[TX_DLY_MSB:TX_DLY_LSB]; // see R6
					rx_dly_nxt = wdat[RX_DLY_MSB:RX_DLY_LSB]; // see R7
				end
				IDX_RX_EQ: rx_eq_nxt = wdat; // see R10
				IDX_RX_LPF: rx_lpf_nxt = wdat; // see R11
				IDX_RX_EQ_EN: rx_eq_en_nxt = wdat; // see R12
				IDX_CLK_OUT: clk_sel_nxt = wdat[CLK_SEL_BIT]; // see R5
				IDX_SER_IF: six_wire_nxt = wdat[SIX_WIRE_BIT]; // see R9
				IDX_ST_CTRL: st_run_nxt = wdat[ST_RUN_BIT];
				IDX_ST_STAT: st_pkts_nxt = '0;
				default: begin
				end
			endcase
		end
	end

	// configuration registers; delays capture the synchronised straps
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			pkt_len_r <= RST_PKT_LEN; // see R1
			gap_len_r <= RST_GAP_LEN; // see R3
			tx_dly_r <= strap_s2_r[7:4]; // see R6
			rx_dly_r <= strap_s2_r[3:0]; // see R7
			rx_eq_r <= RST_RX_EQ;
			rx_lpf_r <= RST_RX_LPF;
			rx_eq_en_r <= RST_RX_EQ_EN;
			clk_sel_r <= RST_CLK_SEL;
			six_wire_r <= RST_SIX_WIRE; // see R9
			st_run_r <= RST_ST_RUN;
			st_pkts_r <= '0;
		end else begin
			pkt_len_r <= pkt_len_nxt;
			gap_len_r <= gap_len_nxt;
			tx_dly_r <= tx_dly_nxt;
			rx_dly_r <= rx_dly_nxt;
			rx_eq_r <= rx_eq_nxt;
			rx_lpf_r <= rx_lpf_nxt;
			rx_eq_en_r <= rx_eq_en_nxt;
			clk_sel_r <= clk_sel_nxt;
			six_wire_r <= six_wire_nxt;
			st_run_r <= st_run_nxt;
			st_pkts_r <= st_pkts_nxt;
		end
	end

	// ----------------------------------------------------------------
	// read mux and acknowledge
	// ----------------------------------------------------------------
	// read data is latched on the request edge and presented with ack;
	// reserved bits and unmapped indices read as zero
	always_comb begin
		rdat_nxt = '0;
		ack_nxt = req && !ack_r;
		case (idx)
			IDX_PKT_LEN: rdat_nxt[REG_W-1:0] = pkt_len_r;
			IDX_GAP_LEN: rdat_nxt[GAP_MSB:0] = gap_len_r; // see R5
			IDX_CLK_DLY: begin
				rdat_nxt[TX_DLY_MSB:TX_DLY_LSB] = tx_dly_r; // see R5
				rdat_nxt[RX_DLY_MSB:RX_DLY_LSB] = rx_dly_r;
			end
			IDX_RX_EQ: rdat_nxt[REG_W-1:0] = rx_eq_r;
			IDX_RX_LPF: rdat_nxt[REG_W-1:0] = rx_lpf_r;
			IDX_RX_EQ_EN: rdat_nxt[REG_W-1:0] = rx_eq_en_r;
			IDX_CLK_OUT: rdat_nxt[CLK_SEL_BIT] = clk_sel_r; // see R5
			IDX_SER_IF: rdat_nxt[SIX_WIRE_BIT] = six_wire_r; // see R5
			IDX_ST_CTRL: rdat_nxt[ST_RUN_BIT] = st_run_r;
			IDX_ST_STAT: begin
				rdat_nxt[ST_BUSY_BIT] = gen_busy;
				rdat_nxt[ST_CNT_MSB:0] = st_pkts_r;
			end
			default: rdat_nxt = '0;
		endcase
		// drop the data again on the ack edge so it never outlives ack
		if (!req || ack_r) begin
			rdat_nxt = '0;
		end
	end

	// bus registers; ack drops the cycle after it is given
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			ack_r <= 1'b0;
			rdat_r <= '0;
		end else begin
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	assign wb_ack_out = ack_r;
	assign wb_dat_out = rdat_r;

	// ----------------------------------------------------------------
	// self-test generator
	// ----------------------------------------------------------------
	selftest_frame_gen u_gen (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.run_in(st_run_r),
		.packet_bytes_in(pkt_len_r), // see R1
		.gap_units_in(gap_len_r), // see R4
		.nibble_out(selftest_nibble_out),
		.nibble_valid_out(selftest_valid_out),
		.packet_done_out(gen_done),
		.busy_out(gen_busy)
	);

	assign selftest_packet_done_out = gen_done;

	// ----------------------------------------------------------------
	// configuration outputs
	// ----------------------------------------------------------------
	// clock-out mux is a plain gate mux; switching it may glitch the pin,
	// acceptable since it only changes for compliance setups
	assign clock_out_out = clk_sel_r ? transmit_test_clock_in : normal_clock_in; // see R8
	assign clock_output_select_out = clk_sel_r;
	assign tx_clock_delay_code_out = tx_dly_r; // see R6
	assign rx_clock_delay_code_out = rx_dly_r; // see R7
	assign receiver_equalizer_word_out = rx_eq_r; // see R10
	assign receiver_lowpass_word_out = rx_lpf_r; // see R11
	assign receiver_equalizer_enable_word_out = rx_eq_en_r; // see R12
	assign six_wire_mode_out = six_wire_r;
	// the differential clock toward the mac exists only in six-wire mode
	assign serial_clock_enable_out = six_wire_r; // see R9

endmodule

// *** hw/selftest_frame_gen.sv ***
// selftest_frame_gen: nibble-wide self-test packet sequencer.
// assumes: length and gap come from the register bank on the same clock;
// they are sampled only at packet start so mid-packet writes are safe.
`timescale 1ns/1ps

module selftest_frame_gen (
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic run_in,
	input wire logic [phy_cfg_pkg::REG_W-1:0] packet_bytes_in,
	input wire logic [phy_cfg_pkg::GAP_MSB:0] gap_units_in,
	output logic [3:0] nibble_out,
	output logic nibble_valid_out,
	output logic packet_done_out,
	output logic busy_out
);
	import phy_cfg_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_SFD_LO, ST_SFD_HI, ST_BODY, ST_GAP} gen_state_t;

	gen_state_t state_r, state_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt;
	logic [REG_W-1:0] len_r, len_nxt;
	logic [GAP_MSB:0] gap_r, gap_nxt;
	logic [7:0] byte_r, byte_nxt;
	logic hi_r, hi_nxt;
	logic [3:0] nib_r, nib_nxt;
	logic val_r, val_nxt;
	logic done_r, done_nxt;

	localparam logic [CNT_W-1:0] LEAD_LAST = CNT_W'(LEAD_NIBBLES - 1);

	// ----------------------------------------------------------------
	// sequencing: lead-in, delimiter, body, gap
	// ----------------------------------------------------------------
	// next-state and next-output computation
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		len_nxt = len_r;
		gap_nxt = gap_r;
		byte_nxt = byte_r;
		hi_nxt = hi_r;
		done_nxt = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (run_in) begin
					state_nxt = ST_LEAD;
					cnt_nxt = LEAD_LAST; // see R2
					len_nxt = packet_bytes_in; // see R1
					gap_nxt = gap_units_in;
				end
			end
			ST_LEAD: begin
				if (cnt_r == '0) begin
					state_nxt = ST_SFD_LO;
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ST_SFD_LO: begin
				state_nxt = ST_SFD_HI; // see R2
			end
			ST_SFD_HI: begin
				byte_nxt = 8'h00;
				hi_nxt = 1'b0;
				// a zero length sends delimiter only, then the gap
				if (len_r == '0) begin
					done_nxt = 1'b1;
					state_nxt = ST_GAP;
					cnt_nxt = CNT_W'({gap_r, 3'b000}); // see R3
				end else begin
					state_nxt = ST_BODY;
					cnt_nxt = CNT_W'({len_r, 1'b0}) - 1'b1; // see R1
				end
			end
			ST_BODY: begin
				hi_nxt = ~hi_r;
				if (hi_r) begin
					byte_nxt = byte_r + 1'b1;
				end
				if (cnt_r == '0) begin
					done_nxt = 1'b1;
					state_nxt = ST_GAP;
					// four bytes per unit, two nibbles per byte
					cnt_nxt = CNT_W'({gap_r, 3'b000}); // see R4
				end else begin
					cnt_nxt = cnt_r - 1'b1;
				end
			end
			ST_GAP: begin
				// gap counts down from units*8 so a zero gap costs one idle nibble
				if (cnt_r <= CNT_W'(1)) begin
					if (run_in) begin
						state_nxt = ST_LEAD;
						cnt_nxt = LEAD_LAST;
						len_nxt = packet_bytes_in;
						gap_nxt = gap_units_in;
					end else begin
						state_nxt = ST_IDLE;
					end
				end else begin
					cnt_nxt = cnt_r - 1'b1; // see R3
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
		// output nibble follows the state being entered
		case (state_nxt)
			ST_LEAD: nib_nxt = LEAD_NIBBLE;
			ST_SFD_LO: nib_nxt = SFD_BYTE[3:0];
			ST_SFD_HI: nib_nxt = SFD_BYTE[7:4];
			ST_BODY: nib_nxt = hi_nxt ? byte_nxt[7:4] : byte_nxt[3:0];
			default: nib_nxt = 4'h0;
		endcase
		val_nxt = (state_nxt != ST_IDLE) && (state_nxt != ST_GAP);
	end

	// state registers
	always_ff @(posedge core_clk_in) begin
		if (!rst_b_in) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			len_r <= RST_PKT_LEN;
			gap_r <= RST_GAP_LEN;
			byte_r <= 8'h00;
			hi_r <= 1'b0;
			nib_r <= 4'h0;
			val_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			len_r <= len_nxt;
			gap_r <= gap_nxt;
			byte_r <= byte_nxt;
			hi_r <= hi_nxt;
			nib_r <= nib_nxt;
			val_r <= val_nxt;
			done_r <= done_nxt;
		end
	end

	assign nibble_out = nib_r;
	assign nibble_valid_out = val_r;
	assign packet_done_out = done_r;
	assign busy_out = (state_r != ST_IDLE);

endmodule

// *** shared/phy_cfg_pkg.sv ***
// phy_cfg_pkg: register indices, field positions, reset values and
// self-test framing constants for the transceiver configuration bank.
// assumes: a word-addressed Wishbone slave, byte address = 4 x index.
package phy_cfg_pkg;

	// ----------------------------------------------------------------
	// bus and register geometry
	// ----------------------------------------------------------------
	localparam int REG_W = 16;
	localparam int WB_DW = 32;
	localparam int WB_AW = 12;
	localparam int WB_SW = 4;
	localparam int IDX_W = 10;

	// register indices (byte address is four times the index)
	localparam logic [IDX_W-1:0] IDX_PKT_LEN = 10'h07b;
	localparam logic [IDX_W-1:0] IDX_GAP_LEN = 10'h07c;
	localparam logic [IDX_W-1:0] IDX_CLK_DLY = 10'h086;
	localparam logic [IDX_W-1:0] IDX_RX_EQ = 10'h08a;
	localparam logic [IDX_W-1:0] IDX_RX_LPF = 10'h0b3;
	localparam logic [IDX_W-1:0] IDX_RX_EQ_EN = 10'h0c0;
	localparam logic [IDX_W-1:0] IDX_CLK_OUT = 10'h0c6;
	localparam logic [IDX_W-1:0] IDX_SER_IF = 10'h0d3;
	localparam logic [IDX_W-1:0] IDX_ST_CTRL = 10'h0e0;
	localparam logic [IDX_W-1:0] IDX_ST_STAT = 10'h0e1;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int GAP_MSB = 7;
	localparam int TX_DLY_MSB = 7;
	localparam int TX_DLY_LSB = 4;
	localparam int RX_DLY_MSB = 3;
	localparam int RX_DLY_LSB = 0;
	localparam int CLK_SEL_BIT = 4;
	localparam int SIX_WIRE_BIT = 14;
	localparam int ST_RUN_BIT = 0;
	localparam int ST_BUSY_BIT = 15;
	localparam int ST_CNT_MSB = 14;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [REG_W-1:0] RST_PKT_LEN = 16'h05dc;
	localparam logic [7:0] RST_GAP_LEN = 8'h7d;
	localparam logic [REG_W-1:0] RST_RX_EQ = 16'h0000;
	localparam logic [REG_W-1:0] RST_RX_LPF = 16'h0000;
	localparam logic [REG_W-1:0] RST_RX_EQ_EN = 16'h0000;
	localparam logic RST_CLK_SEL = 1'b0;
	localparam logic RST_SIX_WIRE = 1'b0;
	localparam logic RST_ST_RUN = 1'b0;

	// ----------------------------------------------------------------
	// self-test framing
	// ----------------------------------------------------------------
	localparam int LEAD_NIBBLES = 13;
	localparam logic [3:0] LEAD_NIBBLE = 4'h5;
	localparam logic [7:0] SFD_BYTE = 8'hd5;
	localparam int GAP_BYTES_PER_UNIT = 4;
	localparam int NIBBLES_PER_BYTE = 2;
	localparam int CNT_W = 18;

endpackage

// *** tb/phy_cfg_regs_sva.sv ***
// phy_cfg_regs_sva: port-level checks of the configuration bank.
// assumes: bound to phy_cfg_regs, single clock, sync active-low reset.
`timescale 1ns/1ps

module phy_cfg_regs_chk
	import phy_cfg_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [phy_cfg_pkg::WB_AW-1:0] wb_adr_in,
	input wire logic [phy_cfg_pkg::WB_SW-1:0] wb_sel_in,
	input wire logic [phy_cfg_pkg::WB_DW-1:0] wb_dat_in,
	input wire logic [phy_cfg_pkg::WB_DW-1:0] wb_dat_out,
	input wire logic wb_ack_out,
	input wire logic transmit_test_clock_in,
	input wire logic normal_clock_in,
	input wire logic clock_out_out,
	input wire logic [phy_cfg_pkg::REG_W-1:0] receiver_equalizer_word_out,
	input wire logic clock_output_select_out,
	input wire logic six_wire_mode_out,
	input wire logic serial_clock_enable_out,
	input wire logic [3:0] selftest_nibble_out,
	input wire logic selftest_valid_out,
	input wire logic selftest_packet_done_out
);
	// ----------------------------------------------------------------
	// bus, register and self-test stream properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);
	logic rd_c;
	assign rd_c = wb_ack_out && wb_cyc_in && wb_stb_in && !wb_we_in;
	ack_next_a: assert property (
		wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out)
		else $error("ack not one cycle after request");
	eq_write_a: assert property (
		wb_ack_out && wb_we_in && wb_sel_in[1:0] == 2'b11 && wb_adr_in[11:2] == IDX_RX_EQ
		|=> receiver_equalizer_word_out == $past(wb_dat_in[15:0]))
		else $error("equalizer word not updated by write");
	idle_zero_a: assert property (!wb_ack_out |-> wb_dat_out == 32'h0000_0000)
		else $error("read data not zero outside ack");
	ser_read_a: assert property (rd_c && wb_adr_in[11:2] == IDX_SER_IF
		|-> wb_dat_out == {17'h00000, six_wire_mode_out, 14'h0000})
		else $error("serial control readback wrong");
	clk_read_a: assert property (rd_c && wb_adr_in[11:2] == IDX_CLK_OUT
		|-> wb_dat_out == {27'h0000000, clock_output_select_out, 4'h0})
		else $error("clock-out control readback wrong");
	clock_output_select_a: assert property (clock_out_out == (clock_output_select_out ?
		transmit_test_clock_in : normal_clock_in)) else $error("clock-out source wrong");
	ser_clk_a: assert property (serial_clock_enable_out == six_wire_mode_out)
		else $error("serial clock enable mismatch");
	lead_in_a: assert property ($rose(selftest_valid_out)
		|-> (selftest_nibble_out == 4'h5)[*8]
		##1 (selftest_nibble_out == 4'h5)[*6] ##1 (selftest_nibble_out == 4'hd))
		else $error("lead-in or delimiter wrong");
	// done marks the first idle cycle; a zero gap may restart right after it
	gap_start_a: assert property (selftest_packet_done_out
		|-> !selftest_valid_out ##1 !selftest_packet_done_out)
		else $error("no idle after packet end");
	wr_c: cover property (wb_ack_out && wb_we_in);
	rd_cv: cover property (rd_c);
	done_c: cover property (selftest_packet_done_out);
endmodule

bind phy_cfg_regs phy_cfg_regs_chk chk_u (.*);

// *** tb/phy_cfg_regs_tb.sv ***
// phy_cfg_regs_tb: table-driven register checks, then self-test stream.
// assumes: host model drives the bus; straps are held static.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module phy_cfg_regs_tb;
	import phy_cfg_pkg::*;
	typedef struct packed {logic we; logic [11:0] a; logic [3:0] s; logic [15:0] d;} row_t;
	logic core_clk_in = 1'b0, rst_b_in = 1'b0, tclk = 1'b0, ack, cyc, stb, we;
	logic [2:0] ndiv = 3'h0;
	logic [11:0] adr;
	logic [3:0] sel, tx_c, rx_c, nib;
	logic [31:0] wd, rd, q;
	logic [15:0] eq_w, lpf_w, en_w;
	logic csel, six, sclk, val, done;
	int err_total = 0, total_checks = 0, wd_cnt = 0, g;
	// reads of reset values, writes, then readbacks; read rows hold expectations
	row_t rows [22] = '{'{0, 12'h1ec, 4'hf, 16'h05dc}, '{0, 12'h1f0, 4'hf, 16'h007d},
		'{0, 12'h34c, 4'hf, 16'h0000}, '{0, 12'h218, 4'hf, 16'h0096},
		'{1, 12'h1ec, 4'hf, 16'h0004}, '{1, 12'h1f0, 4'hf, 16'hff03},
		'{1, 12'h218, 4'hf, 16'hffa3}, '{1, 12'h228, 4'hf, 16'h010f},
		'{1, 12'h2cc, 4'hf, 16'h000c}, '{1, 12'h300, 4'hf, 16'ha5a5},
		'{1, 12'h318, 4'hf, 16'hffff}, '{1, 12'h34c, 4'hf, 16'hffff},
		'{1, 12'h3fc, 4'hf, 16'h1234}, '{1, 12'h228, 4'h1, 16'hffff},
		'{0, 12'h1f0, 4'hf, 16'h0003}, '{0, 12'h218, 4'hf, 16'h00a3},
		'{0, 12'h228, 4'hf, 16'h010f}, '{0, 12'h2cc, 4'hf, 16'h000c},
		'{0, 12'h300, 4'hf, 16'ha5a5}, '{0, 12'h318, 4'hf, 16'h0010},
		'{0, 12'h34c, 4'hf, 16'h4000}, '{0, 12'h3fc, 4'hf, 16'h0000}};
	always #2.5 core_clk_in = ~core_clk_in;
	// clock-out sources change only at the sampling edge
	always @(posedge core_clk_in) begin
		tclk <= ~tclk;
		ndiv <= ndiv + 3'h1;
	end
	wb_host_model host_u (.core_clk_in(core_clk_in), .wb_ack_in(ack), .wb_dat_in(rd),
		.wb_cyc_out(cyc), .wb_stb_out(stb), .wb_we_out(we), .wb_adr_out(adr),
		.wb_sel_out(sel), .wb_dat_out(wd));
	phy_cfg_regs dut_u (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd),
		.wb_dat_out(rd), .wb_ack_out(ack), .tx_delay_strap_in(4'h9), .rx_delay_strap_in(4'h6),
		.transmit_test_clock_in(tclk), .normal_clock_in(ndiv[2]), .clock_out_out(),
		.tx_clock_delay_code_out(tx_c), .rx_clock_delay_code_out(rx_c),
		.receiver_equalizer_word_out(eq_w), .receiver_lowpass_word_out(lpf_w),
		.receiver_equalizer_enable_word_out(en_w), .clock_output_select_out(csel),
		.six_wire_mode_out(six), .serial_clock_enable_out(sclk),
		.selftest_nibble_out(nib), .selftest_valid_out(val), .selftest_packet_done_out(done));
	task automatic complete_run();
		$display("checks=%0d mismatches=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// watchdog: the whole sequence needs well under 2000 cycles
	always @(posedge core_clk_in) begin
		wd_cnt <= wd_cnt + 1;
		if (wd_cnt == 2000) begin
			err_total++;
			complete_run();
		end
	end
	function automatic logic [3:0] exp_nib(input int i);
		logic [7:0] b;
		b = 8'((i - 15) / 2);
		if (i < 14) return 4'h5;
		if (i == 14) return 4'hd;
		return i[0] ? b[3:0] : b[7:4];
	endfunction
	initial begin
		repeat (12) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		foreach (rows[i]) begin
			host_u.xfer(rows[i].we, rows[i].a, rows[i].s, {16'h0000, rows[i].d}, q);
			if (!rows[i].we) `CHK(q, {16'h0000, rows[i].d})
		end
		`CHK({tx_c, rx_c}, 8'ha3)
		`CHK({eq_w, lpf_w, en_w}, 48'h010f_000c_a5a5)
		`CHK({csel, six, sclk}, 3'b111)
		// self-test: 4-byte packets, gap of 3 units
		host_u.xfer(1'b1, 12'h380, 4'hf, 32'h0000_0001, q);
		// look just after the edge so the first lead nibble is not skipped
		#1;
		g = 0;
		while (val !== 1'b1 && g < 100) begin
			@(posedge core_clk_in) #1;
			g++;
		end
		for (int i = 0; i < 23; i++) begin
			`CHK(nib, exp_nib(i))
			// done marks the first gap cycle, not the last body nibble
			if (i == 22) `CHK(done, 1'b0)
			@(posedge core_clk_in) #1;
		end
		`CHK({val, done}, 2'b01)
		g = 0;
		while (val !== 1'b1 && g < 100) begin
			@(posedge core_clk_in) #1;
			g++;
		end
		`CHK(g, 24)
		// status: busy on the second packet, one packet counted
		host_u.xfer(1'b0, 12'h384, 4'hf, 32'h0000_0000, q);
		`CHK(q, 32'h0000_8001)
		host_u.xfer(1'b1, 12'h380, 4'hf, 32'h0000_0000, q);
		// mid-run reset brings back reset values and strap delays
		rst_b_in <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		rst_b_in <= 1'b1;
		host_u.xfer(1'b0, 12'h1ec, 4'hf, 32'h0000_0000, q);
		`CHK(q, {16'h0000, RST_PKT_LEN})
		`CHK({tx_c, rx_c}, 8'h96)
		complete_run();
	end
endmodule

// *** tb/wb_host_model.sv ***
// wb_host_model: management host issuing classic Wishbone single cycles.
// assumes: slave answers with a registered ack; the bench watchdog bounds waits.
`timescale 1ns/1ps

module wb_host_model (
	input wire logic core_clk_in,
	input wire logic wb_ack_in,
	input wire logic [31:0] wb_dat_in,
	output logic wb_cyc_out,
	output logic wb_stb_out,
	output logic wb_we_out,
	output logic [11:0] wb_adr_out,
	output logic [3:0] wb_sel_out,
	output logic [31:0] wb_dat_out
);
	initial begin
		wb_cyc_out = 1'b0;
		wb_stb_out = 1'b0;
		wb_we_out = 1'b0;
		wb_adr_out = 12'h000;
		wb_sel_out = 4'h0;
		wb_dat_out = 32'h0000_0000;
	end
	// one single cycle with the caller's lane selects; request held until ack is sampled
	task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] s,
			input logic [31:0] d, output logic [31:0] q);
		@(posedge core_clk_in);
		wb_cyc_out <= 1'b1;
		wb_stb_out <= 1'b1;
		wb_we_out <= w;
		wb_adr_out <= a;
		wb_sel_out <= s;
		wb_dat_out <= d;
		do @(posedge core_clk_in); while (wb_ack_in !== 1'b1);
		q = wb_dat_in;
		wb_cyc_out <= 1'b0;
		wb_stb_out <= 1'b0;
		// released data line shows the inverse, not a stale match
		wb_dat_out <= ~d;
		@(posedge core_clk_in);
	endtask
endmodule
